//--- shared/gpov_pkg.sv
// Constants and helpers for the general-purpose output value block
package gpov_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int GEN_PINS = 5;
    localparam int LEG_PINS = 20;
    localparam int HI_BITS = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] GEN_VAL_OFS = 16'h00EF;
    localparam logic [ADDR_W-1:0] LEG_LO_OFS = 16'h00F0;
    localparam logic [ADDR_W-1:0] LEG_MID_OFS = 16'h00F1;
    localparam logic [ADDR_W-1:0] LEG_HI_OFS = 16'h00F2;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] VAL_RST = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
    localparam int LEG_MID_BASE = 8;
    localparam int LEG_HI_BASE = 16;

    // ------------------------------------------------------------
    // Function selector codes
    // ------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_OUTPUT = 3'h1;

    function automatic logic gpov_is_output(input logic [SEL_W-1:0] sel);
        gpov_is_output = (sel == SEL_OUTPUT);
    endfunction : gpov_is_output

endpackage : gpov_pkg

//--- shared/gpov_if.sv
// Carrier between the value registers and the pin gate
`timescale 1ns/1ps
interface gpov_if;
    logic [gpov_pkg::GEN_PINS-1:0] gen_val;
    logic [gpov_pkg::LEG_PINS-1:0] leg_val;
    logic [gpov_pkg::GEN_PINS*gpov_pkg::SEL_W-1:0] gen_sel;
    logic [gpov_pkg::LEG_PINS-1:0] leg_gpo;
    logic [gpov_pkg::LEG_PINS*gpov_pkg::SEL_W-1:0] leg_sel;

    modport regs (output gen_val, output leg_val, output gen_sel, output leg_gpo, output leg_sel);
    modport gate (input gen_val, input leg_val, input gen_sel, input leg_gpo, input leg_sel);
endinterface : gpov_if

//--- verilog/gpov_gate.sv
// Pin gate: stored values reach pins only in plain output mode
`timescale 1ns/1ps
module gpov_gate (
    input wire logic clk_i,
    input wire logic arst_n_i,
    gpov_if.gate bus,
    output logic [gpov_pkg::GEN_PINS-1:0] gen_level_o,
    output logic [gpov_pkg::GEN_PINS-1:0] gen_oe_o,
    output logic [gpov_pkg::LEG_PINS-1:0] leg_level_o,
    output logic [gpov_pkg::LEG_PINS-1:0] leg_oe_o
);

    logic [gpov_pkg::GEN_PINS-1:0] gen_mode;
    logic [gpov_pkg::LEG_PINS-1:0] leg_mode;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < gpov_pkg::GEN_PINS; i++) begin
            gen_mode[i] = gpov_pkg::gpov_is_output(bus.gen_sel[i*gpov_pkg::SEL_W +: gpov_pkg::SEL_W]);
        end
        for (int j = 0; j < gpov_pkg::LEG_PINS; j++) begin
            leg_mode[j] = bus.leg_gpo[j] &
                gpov_pkg::gpov_is_output(bus.leg_sel[j*gpov_pkg::SEL_W +: gpov_pkg::SEL_W]);
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // general pin drive
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gen_level_o <= '0;
            gen_oe_o <= '0;
        end else begin
            gen_level_o <= bus.gen_val & gen_mode;
            gen_oe_o <= gen_mode;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            leg_level_o <= '0;
            leg_oe_o <= '0;
        end else begin
            leg_level_o <= bus.leg_val & leg_mode;
            leg_oe_o <= leg_mode;
        end
    end

endmodule : gpov_gate

//--- verilog/gpov_top.sv
// Output value registers for general pins and output legs
`timescale 1ns/1ps
module gpov_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [gpov_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [gpov_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [gpov_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_hit_o,
    input wire logic [gpov_pkg::GEN_PINS*gpov_pkg::SEL_W-1:0] gen_sel_i,
    input wire logic [gpov_pkg::LEG_PINS-1:0] leg_gpo_i,
    input wire logic [gpov_pkg::LEG_PINS*gpov_pkg::SEL_W-1:0] leg_sel_i,
    output logic [gpov_pkg::GEN_PINS-1:0] gen_level_o,
    output logic [gpov_pkg::GEN_PINS-1:0] gen_oe_o,
    output logic [gpov_pkg::LEG_PINS-1:0] leg_level_o,
    output logic [gpov_pkg::LEG_PINS-1:0] leg_oe_o
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [gpov_pkg::GEN_PINS-1:0] gen_q;
    logic [gpov_pkg::DATA_W-1:0] leg_lo_q;
    logic [gpov_pkg::DATA_W-1:0] leg_mid_q;
    logic [gpov_pkg::HI_BITS-1:0] leg_hi_q;
    logic [gpov_pkg::DATA_W-1:0] rdata_d;
    logic [gpov_pkg::DATA_W-1:0] rdata_q;
    logic sel_gen;
    logic sel_lo;
    logic sel_mid;
    logic sel_hi;

    assign sel_gen = (reg_addr_i == gpov_pkg::GEN_VAL_OFS);
    assign sel_lo = (reg_addr_i == gpov_pkg::LEG_LO_OFS);
    assign sel_mid = (reg_addr_i == gpov_pkg::LEG_MID_OFS);
    assign sel_hi = (reg_addr_i == gpov_pkg::LEG_HI_OFS);
    // Hit is combinational so the port decoder can tell foreign addresses at once
    assign reg_hit_o = sel_gen | sel_lo | sel_mid | sel_hi;

    // ------------------------------------------------------------
    // Value registers
    // ------------------------------------------------------------
    // reserved bits dropped
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gen_q <= gpov_pkg::VAL_RST[gpov_pkg::GEN_PINS-1:0];
        end else if (reg_wr_i && sel_gen) begin
            gen_q <= reg_wdata_i[gpov_pkg::GEN_PINS-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            leg_lo_q <= gpov_pkg::VAL_RST;
        end else if (reg_wr_i && sel_lo) begin
            leg_lo_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            leg_mid_q <= gpov_pkg::VAL_RST;
        end else if (reg_wr_i && sel_mid) begin
            leg_mid_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            leg_hi_q <= gpov_pkg::VAL_RST[gpov_pkg::HI_BITS-1:0];
        end else if (reg_wr_i && sel_hi) begin
            leg_hi_q <= reg_wdata_i[gpov_pkg::HI_BITS-1:0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        if (sel_gen) begin
            rdata_d[gpov_pkg::GEN_PINS-1:0] = gen_q;
        end else if (sel_lo) begin
            rdata_d = leg_lo_q;
        end else if (sel_mid) begin
            rdata_d = leg_mid_q;
        end else if (sel_hi) begin
            rdata_d[gpov_pkg::HI_BITS-1:0] = leg_hi_q;
        end
    end

    // Read data holds until the next read so a slow serial shifter can take it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= gpov_pkg::RDATA_RST;
        end else if (reg_rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------
    // Pin gate
    // ------------------------------------------------------------
    gpov_if link ();

    assign link.gen_val = gen_q;
    assign link.leg_val = {leg_hi_q, leg_mid_q, leg_lo_q};
    assign link.gen_sel = gen_sel_i;
    assign link.leg_gpo = leg_gpo_i;
    assign link.leg_sel = leg_sel_i;

    gpov_gate i_gpov_gate (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .bus(link.gate),
        .gen_level_o(gen_level_o),
        .gen_oe_o(gen_oe_o),
        .leg_level_o(leg_level_o),
        .leg_oe_o(leg_oe_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_gen0_drive;
        @(posedge clk_i) disable iff (!arst_n_i)
        (gen_sel_i[2:0] == gpov_pkg::SEL_OUTPUT) |=> (gen_oe_o[0] && gen_level_o[0] == $past(gen_q[0]));
    endproperty
    a_gen0_drive: assert property (p_gen0_drive) else $error("general pin zero not driven from bit 0");

    property p_gen4_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_wr_i && sel_gen && gen_sel_i[14:12] == gpov_pkg::SEL_OUTPUT) ##1
        (gen_sel_i[14:12] == gpov_pkg::SEL_OUTPUT) |=> (gen_level_o[4] == $past(reg_wdata_i[4], 2));
    endproperty
    a_gen4_write: assert property (p_gen4_write) else $error("general pin four missed written bit 4");

    property p_gen_rsvd;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_rd_i && sel_gen) |=> (reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[4:0] == $past(gen_q));
    endproperty
    a_gen_rsvd: assert property (p_gen_rsvd) else $error("general value readback wrong");

    property p_leg0_drive;
        @(posedge clk_i) disable iff (!arst_n_i)
        (leg_gpo_i[0] && leg_sel_i[2:0] == gpov_pkg::SEL_OUTPUT) |=>
        (leg_oe_o[0] && leg_level_o[0] == $past(leg_lo_q[0]));
    endproperty
    a_leg0_drive: assert property (p_leg0_drive) else $error("pair zero positive leg not driven");

    property p_pair3_neg;
        @(posedge clk_i) disable iff (!arst_n_i)
        (leg_gpo_i[7] && leg_sel_i[23:21] == gpov_pkg::SEL_OUTPUT) |=> (leg_level_o[7] == $past(leg_lo_q[7]));
    endproperty
    a_pair3_neg: assert property (p_pair3_neg) else $error("pair three negative leg wrong");

    property p_pair7_neg;
        @(posedge clk_i) disable iff (!arst_n_i)
        (leg_gpo_i[15] && leg_sel_i[47:45] == gpov_pkg::SEL_OUTPUT) |=> (leg_level_o[15] == $past(leg_mid_q[7]));
    endproperty
    a_pair7_neg: assert property (p_pair7_neg) else $error("pair seven negative leg wrong");

    property p_pair9_neg;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_rd_i && sel_hi) |=> (reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[3] == $past(leg_hi_q[3]));
    endproperty
    a_pair9_neg: assert property (p_pair9_neg) else $error("high leg register readback wrong");

    property p_sel_other;
        @(posedge clk_i) disable iff (!arst_n_i)
        (gen_sel_i[5:3] != gpov_pkg::SEL_OUTPUT) |=> (!gen_oe_o[1] && !gen_level_o[1]);
    endproperty
    a_sel_other: assert property (p_sel_other) else $error("general pin one driven outside output mode");

    property p_keep_val;
        @(posedge clk_i) disable iff (!arst_n_i)
        (!leg_gpo_i[18] && !(reg_wr_i && sel_hi)) |=> ($stable(leg_hi_q) && !leg_oe_o[18]);
    endproperty
    a_keep_val: assert property (p_keep_val) else $error("stored leg value lost or pin driven");

    property p_pair4_pos;
        @(posedge clk_i) disable iff (!arst_n_i)
        (leg_gpo_i[gpov_pkg::LEG_MID_BASE] && leg_sel_i[26:24] == gpov_pkg::SEL_OUTPUT) |=>
        (leg_oe_o[gpov_pkg::LEG_MID_BASE] && leg_level_o[gpov_pkg::LEG_MID_BASE] == $past(leg_mid_q[0]));
    endproperty
    a_pair4_pos: assert property (p_pair4_pos) else $error("pair four positive leg not driven");

    property p_pair8_pos;
        @(posedge clk_i) disable iff (!arst_n_i)
        (leg_gpo_i[gpov_pkg::LEG_HI_BASE] && leg_sel_i[50:48] == gpov_pkg::SEL_OUTPUT) |=>
        (leg_oe_o[gpov_pkg::LEG_HI_BASE] && leg_level_o[gpov_pkg::LEG_HI_BASE] == $past(leg_hi_q[0]));
    endproperty
    a_pair8_pos: assert property (p_pair8_pos) else $error("pair eight positive leg not driven");

    property p_gen_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_wr_i && sel_gen) |=> (gen_q == $past(reg_wdata_i[gpov_pkg::GEN_PINS-1:0]));
    endproperty
    a_gen_write: assert property (p_gen_write) else $error("general value write not stored");

    property p_lo_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_wr_i && sel_lo) |=> (leg_lo_q == $past(reg_wdata_i));
    endproperty
    a_lo_write: assert property (p_lo_write) else $error("low leg value write not stored");

    property p_hi_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_wr_i && sel_hi) |=> (leg_hi_q == $past(reg_wdata_i[gpov_pkg::HI_BITS-1:0]));
    endproperty
    a_hi_write: assert property (p_hi_write) else $error("high leg value write not stored");

    property p_gen_keep;
        @(posedge clk_i) disable iff (!arst_n_i)
        (gen_sel_i[2:0] != gpov_pkg::SEL_OUTPUT && !(reg_wr_i && sel_gen)) |=> ($stable(gen_q) && !gen_oe_o[0]);
    endproperty
    a_gen_keep: assert property (p_gen_keep) else $error("general value lost or pin zero driven");

endmodule : gpov_top

//--- verification/gpov_top_tb.sv
// Self-checking testbench for the general-purpose output value block
`timescale 1ns/1ps
module gpov_top_tb;
    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic reg_hit_o;
    logic [14:0] gen_sel_i = '0;
    logic [19:0] leg_gpo_i = '0;
    logic [59:0] leg_sel_i = '0;
    logic [4:0] gen_level_o, gen_oe_o;
    logic [19:0] leg_level_o, leg_oe_o;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    logic [7:0] rv;

    gpov_top i_gpov_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
        .gen_sel_i(gen_sel_i), .leg_gpo_i(leg_gpo_i), .leg_sel_i(leg_sel_i), .gen_level_o(gen_level_o),
        .gen_oe_o(gen_oe_o), .leg_level_o(leg_level_o), .leg_oe_o(leg_oe_o));

    always #5 clk_i = ~clk_i;

    // Hang guard: whole run needs under a hundred cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i) #1;
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(posedge clk_i) #1;
        reg_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i) #1;
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(posedge clk_i) #1;
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
    endtask : rd

    // Pins settle one edge after the write edge; two spare edges
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            rd(16'h00EF + 16'(i), rv);
            check(32'(rv), 32'h0);
        end
        check(32'(gen_level_o), 32'h0);
        check(32'(leg_level_o), 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_gen();
        logic [7:0] pats [2] = '{8'hEA, 8'h15};
        gen_sel_i = {5{3'h1}};
        foreach (pats[k]) begin
            wr(16'h00EF, pats[k]);
            settle();
            check(32'(gen_oe_o), 32'h1F);
            check(32'(gen_level_o), 32'(pats[k] & 8'h1F));
            rd(16'h00EF, rv);
            check(32'(rv), 32'(pats[k] & 8'h1F));
        end
        $display("test general pins done");
    endtask : t_gen

    task automatic t_legs();
        leg_gpo_i = 20'hFFFFF;
        leg_sel_i = {20{3'h1}};
        wr(16'h00F0, 8'h96);
        wr(16'h00F1, 8'h5A);
        wr(16'h00F2, 8'hFC);
        settle();
        check(32'(leg_oe_o), 32'hFFFFF);
        check(32'(leg_level_o), 32'hC5A96);
        rd(16'h00F1, rv);
        check(32'(rv), 32'h5A);
        rd(16'h00F2, rv);
        check(32'(rv), 32'h0C);
        $display("test output legs done");
    endtask : t_legs

    task automatic t_modes();
        // Only code 001 lets the stored bits reach the pins
        for (int c = 0; c < 8; c++) begin
            gen_sel_i = {5{3'(c)}};
            leg_sel_i = {20{3'(c)}};
            settle();
            check(32'(gen_oe_o), (c == 1) ? 32'h1F : 32'h0);
            check(32'(gen_level_o), (c == 1) ? 32'h15 : 32'h0);
            check(32'(leg_level_o), (c == 1) ? 32'hC5A96 : 32'h0);
            check(32'(leg_oe_o), (c == 1) ? 32'hFFFFF : 32'h0);
        end
        // Selectors back to output so only the leg enable decides
        gen_sel_i = {5{3'h1}};
        leg_sel_i = {20{3'h1}};
        leg_gpo_i = 20'h00000;
        settle();
        check(32'(leg_oe_o), 32'h0);
        check(32'(gen_oe_o), 32'h1F);
        leg_gpo_i = 20'h0000F;
        settle();
        check(32'(leg_oe_o), 32'h0000F);
        check(32'(leg_level_o), 32'h00006);
        rd(16'h00EF, rv);
        check(32'(rv), 32'h15);
        $display("test modes done");
    endtask : t_modes

    task automatic t_unmapped();
        wr(16'h00EE, 8'hFF);
        wr(16'h00F3, 8'hFF);
        check(32'(reg_hit_o), 32'h0);
        rd(16'h00F3, rv);
        check(32'(rv), 32'h0);
        check(32'(reg_hit_o), 32'h0);
        rd(16'h00EF, rv);
        check(32'(rv), 32'h15);
        rd(16'h00F2, rv);
        check(32'(rv), 32'h0C);
        rd(16'h00F0, rv);
        check(32'(rv), 32'h96);
        check(32'(reg_hit_o), 32'h1);
        $display("test unmapped done");
    endtask : t_unmapped

    // Reset in mid-run clears pins at once and values by the next read
    task automatic t_reset_mid();
        @(posedge clk_i) #1;
        arst_n_i = 1'b0;
        @(posedge clk_i) #1;
        check(32'(gen_oe_o), 32'h0);
        check(32'(gen_level_o), 32'h0);
        check(32'(leg_oe_o), 32'h0);
        check(32'(leg_level_o), 32'h0);
        arst_n_i = 1'b1;
        t_reset();
        check(32'(gen_oe_o), 32'h1F);
        check(32'(leg_oe_o), 32'h0000F);
        $display("test mid-run reset done");
    endtask : t_reset_mid

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (3) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        t_reset();
        t_gen();
        t_legs();
        t_modes();
        t_unmapped();
        t_reset_mid();
        final_report();
    end
endmodule : gpov_top_tb
